// ==== hdl/bus_matrix_consts.vh ====
// constants for the six layer bus matrix
`ifndef BUS_MATRIX_CONSTS_VH
`define BUS_MATRIX_CONSTS_VH
// master port numbers
`define MST_CPU_INSTR 3'h0
`define MST_CPU_DATA 3'h1
`define MST_XFER_ENGINE 3'h2
`define MST_USB_HOST 3'h3
`define MST_IMAGE_CAPTURE 3'h4
`define MST_ETHERNET 3'h5
// slave port numbers
`define SLV_FLASH 3'h0
`define SLV_SRAM 3'h1
`define SLV_ROM_USBH 3'h2
`define SLV_EXT_MEM 3'h3
`define SLV_RESERVED 3'h4
`define SLV_PERIPH 3'h5
// decoded regions
`define RGN_NONE 3'h0
`define RGN_FLASH 3'h1
`define RGN_SRAM 3'h2
`define RGN_ROM 3'h3
`define RGN_USBH 3'h4
`define RGN_EXT 3'h5
`define RGN_PERIPH 3'h6
// allowed masters per region, bit n is master n
`define ACC_FLASH 6'h23
`define ACC_SRAM 6'h3F
`define ACC_ROM 6'h07
`define ACC_USBH 6'h03
`define ACC_EXT 6'h3F
`define ACC_PERIPH 6'h07
`define ACC_NONE 6'h00
// first level: 256 MB banks in addr[31:28]
`define BANK_INTMEM 4'h0
`define BANK_EXT_LO 4'h1
`define BANK_EXT_HI 4'h7
`define BANK_PERIPH 4'hF
// second level: 1 MB internal areas in addr[27:20]
`define AREA_BOOT 8'h00
`define AREA_ROM 8'h01
`define AREA_FLASH 8'h02
`define AREA_SRAM 8'h03
`define AREA_USBH 8'h05
// boot select bit position in the nonvolatile bits
`define BOOT_BIT_IDX 3
// cycles after reset release before the boot bit is trusted
`define BOOT_WAIT_CYCLES 2'h3
// default master kinds
`define DM_NONE 2'h0
`define DM_LAST 2'h1
`define DM_FIXED 2'h2
`endif

// ==== hdl/six_layer_bus_matrix.v ====
// six layer bus matrix: per-master decoders, per-slave arbiters, boot and remap
`timescale 1ns/1ps
`default_nettype none
`include "bus_matrix_consts.vh"
module six_layer_bus_matrix #(
  parameter NUM_M = 6,
  parameter NUM_S = 6,
  parameter DW = 32,
  parameter AW = 32,
  parameter SLOT_W = 8
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // boot and remap control
  input wire [3:0] general_nonvolatile_bit_i,
  input wire remap_i,
  output wire boot_source_select_o,
  // arbitration setup, one field per slave
  input wire [NUM_S-1:0] rr_mode_i,
  input wire [2*NUM_S-1:0] dm_type_i,
  input wire [3*NUM_S-1:0] dm_fixed_i,
  input wire [SLOT_W*NUM_S-1:0] slot_limit_i,
  // master layers
  input wire [NUM_M-1:0] m_req_i,
  input wire [NUM_M-1:0] m_last_i,
  input wire [NUM_M-1:0] m_write_i,
  input wire [AW*NUM_M-1:0] m_addr_i,
  input wire [DW*NUM_M-1:0] m_wdata_i,
  output wire [NUM_M-1:0] m_ready_o,
  output wire [NUM_M-1:0] m_rvalid_o,
  output wire [NUM_M-1:0] m_err_o,
  output wire [DW*NUM_M-1:0] m_rdata_o,
  // slave ports
  output wire [NUM_S-1:0] s_sel_o,
  output wire [NUM_S-1:0] s_write_o,
  output wire [NUM_S-1:0] s_last_o,
  output wire [AW*NUM_S-1:0] s_addr_o,
  output wire [DW*NUM_S-1:0] s_wdata_o,
  output wire [3*NUM_S-1:0] s_master_o,
  input wire [NUM_S-1:0] s_ready_i,
  input wire [DW*NUM_S-1:0] s_rdata_i
);
  ////////////////////////////////////////////////////////////////////////
  // shared address map, used by every master decoder
  function [2:0] decode_region;
    input [AW-1:0] addr;
    input remap;
    input boot_flash;
    reg [3:0] bank;
    reg [7:0] area;
    begin
      bank = addr[31:28];
      area = addr[27:20];
      decode_region = `RGN_NONE;
      if (bank == `BANK_INTMEM)
      begin
        case (area)
          `AREA_BOOT: decode_region = remap ? `RGN_SRAM : (boot_flash ? `RGN_FLASH : `RGN_ROM);
          `AREA_ROM: decode_region = `RGN_ROM;
          `AREA_FLASH: decode_region = `RGN_FLASH;
          `AREA_SRAM: decode_region = `RGN_SRAM;
          `AREA_USBH: decode_region = `RGN_USBH;
          default: decode_region = `RGN_NONE;
        endcase
      end
      else if (bank >= `BANK_EXT_LO && bank <= `BANK_EXT_HI)
        decode_region = `RGN_EXT;
      else if (bank == `BANK_PERIPH)
        decode_region = `RGN_PERIPH;
    end
  endfunction

  // region to slave port number
  function [2:0] region_slave;
    input [2:0] rgn;
    begin
      case (rgn)
        `RGN_FLASH: region_slave = `SLV_FLASH;
        `RGN_SRAM: region_slave = `SLV_SRAM;
        `RGN_ROM: region_slave = `SLV_ROM_USBH;
        `RGN_USBH: region_slave = `SLV_ROM_USBH;
        `RGN_EXT: region_slave = `SLV_EXT_MEM;
        `RGN_PERIPH: region_slave = `SLV_PERIPH;
        default: region_slave = `SLV_RESERVED;
      endcase
    end
  endfunction

  // masters allowed into each region
  function [5:0] region_access;
    input [2:0] rgn;
    begin
      case (rgn)
        `RGN_FLASH: region_access = `ACC_FLASH;
        `RGN_SRAM: region_access = `ACC_SRAM;
        `RGN_ROM: region_access = `ACC_ROM;
        `RGN_USBH: region_access = `ACC_USBH;
        `RGN_EXT: region_access = `ACC_EXT;
        `RGN_PERIPH: region_access = `ACC_PERIPH;
        default: region_access = `ACC_NONE;
      endcase
    end
  endfunction

  // default master setup made safe: a fixed default past the last layer would
  // park the grant on a layer that does not exist, so it falls back to none
  function [1:0] clean_dm;
    input [1:0] kind;
    input [2:0] fixed;
    begin
      if (kind == `DM_FIXED && fixed >= NUM_M)
        clean_dm = `DM_NONE;
      else
        clean_dm = kind;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // boot select capture: three stage synchroniser, taken once after reset
  reg [2:0] nv_sync;
  reg [1:0] boot_wait;
  reg boot_armed;
  reg boot_flash;

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      nv_sync <= 3'h0;
    else
      nv_sync <= {nv_sync[1:0], general_nonvolatile_bit_i[`BOOT_BIT_IDX]};
  end

  // waits for the chain to refill, then latches once the last two stages agree
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      boot_wait <= `BOOT_WAIT_CYCLES;
      boot_armed <= 1'b1;
      boot_flash <= 1'b0;
    end
    else if (boot_wait != 2'h0)
      boot_wait <= boot_wait - 2'h1;
    else if (boot_armed && (nv_sync[2] == nv_sync[1]))
    begin
      boot_flash <= nv_sync[2];
      boot_armed <= 1'b0;
    end
  end

  assign boot_source_select_o = boot_flash;

  ////////////////////////////////////////////////////////////////////////
  // per-master decode, legality and response
  // a refused request is answered at once, so a bad master never waits on a slave
  wire [3*NUM_M-1:0] tgt;
  wire [NUM_M-1:0] legal;
  wire [NUM_M-1:0] bad;
  wire [NUM_M*NUM_S-1:0] grant;
  wire [3*NUM_S-1:0] owner;

  genvar m;
  genvar s;
  generate
    for (m = 0; m < NUM_M; m = m + 1)
    begin : g_layer
      wire [2:0] rgn;
      wire [5:0] acc;
      wire [2:0] t;
      wire ok_done;
      reg err_q;
      reg rvalid_q;
      reg [DW-1:0] rdata_q;

      // own decoder per master, same map for all
      assign rgn = decode_region(m_addr_i[m*AW +: AW], remap_i, boot_flash);
      assign acc = region_access(rgn);
      assign t = region_slave(rgn);
      assign tgt[m*3 +: 3] = t;
      assign legal[m] = acc[m];
      assign bad[m] = m_req_i[m] & ~acc[m];
      assign ok_done = s_sel_o[t] & grant[t*NUM_M + m] & s_ready_i[t];
      assign m_ready_o[m] = bad[m] | ok_done;

      // abort and read data come back one cycle after the beat is taken
      always @(posedge sys_clk_i)
      begin
        if (rst_i)
        begin
          err_q <= 1'b0;
          rvalid_q <= 1'b0;
          rdata_q <= {DW{1'b0}};
        end
        else
        begin
          err_q <= bad[m];
          rvalid_q <= ok_done & ~m_write_i[m];
          if (ok_done & ~m_write_i[m])
            rdata_q <= s_rdata_i[t*DW +: DW];
        end
      end

      // registered answers back to the master
      assign m_err_o[m] = err_q;
      assign m_rvalid_o[m] = rvalid_q;
      assign m_rdata_o[m*DW +: DW] = rdata_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // per-slave arbitration and forwarding
    for (s = 0; s < NUM_S; s = s + 1)
    begin : g_slave
      wire [NUM_M-1:0] sreq;
      wire [NUM_M-1:0] gnt;
      wire [2:0] own;
      wire [1:0] dm_kind;

      for (m = 0; m < NUM_M; m = m + 1)
      begin : g_req
        assign sreq[m] = m_req_i[m] & legal[m] & (tgt[m*3 +: 3] == s);
      end

      // default master kind checked against the layer count
      assign dm_kind = clean_dm(dm_type_i[s*2 +: 2], dm_fixed_i[s*3 +: 3]);

      // own arbiter per slave with its own setup fields
      slave_arbiter #(
        .NUM_M(NUM_M),
        .SLOT_W(SLOT_W)
      ) u_arb (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .req_i(sreq),
        .last_i(m_last_i),
        .done_i(s_sel_o[s] & s_ready_i[s]),
        .rr_mode_i(rr_mode_i[s]),
        .dm_type_i(dm_kind),
        .dm_fixed_i(dm_fixed_i[s*3 +: 3]),
        .slot_limit_i(slot_limit_i[s*SLOT_W +: SLOT_W]),
        .grant_o(gnt),
        .owner_o(own)
      );

      // owner's fields forwarded to the slave while it is selected
      assign grant[s*NUM_M +: NUM_M] = gnt;
      assign owner[s*3 +: 3] = own;
      assign s_sel_o[s] = |(gnt & sreq);
      assign s_write_o[s] = m_write_i[own];
      assign s_last_o[s] = m_last_i[own];
      assign s_addr_o[s*AW +: AW] = m_addr_i[own*AW +: AW];
      assign s_wdata_o[s*DW +: DW] = m_wdata_i[own*DW +: DW];
      assign s_master_o[s*3 +: 3] = owner[s*3 +: 3];
    end
  endgenerate
endmodule
`default_nettype wire

// ==== hdl/slave_arbiter.v ====
// per-slave arbiter with fixed or round-robin choice and slot breaking
`timescale 1ns/1ps
`default_nettype none
`include "bus_matrix_consts.vh"
module slave_arbiter #(
  parameter NUM_M = 6,
  parameter SLOT_W = 8
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // requests from the master layers
  input wire [NUM_M-1:0] req_i,
  input wire [NUM_M-1:0] last_i,
  input wire done_i,
  // arbitration setup
  input wire rr_mode_i,
  input wire [1:0] dm_type_i,
  input wire [2:0] dm_fixed_i,
  input wire [SLOT_W-1:0] slot_limit_i,
  // grant
  output wire [NUM_M-1:0] grant_o,
  output wire [2:0] owner_o
);
  ////////////////////////////////////////////////////////////////////////
  // winner choice: lowest index, or first requester after the last winner
  function [2:0] pick;
    input [NUM_M-1:0] r;
    input rr;
    input [2:0] after;
    integer i;
    integer k;
    reg found;
    begin
      pick = 3'h0;
      found = 1'b0;
      for (i = 0; i < NUM_M; i = i + 1)
      begin
        k = rr ? (after + 1 + i) % NUM_M : i;
        if (!found && r[k])
        begin
          pick = k[2:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  // highest layer, so round-robin starts at master 0 after reset
  localparam [31:0] LAST_M = NUM_M - 1;
  reg [2:0] owner;
  reg own_v;
  reg [2:0] last_win;
  reg [SLOT_W-1:0] slot_cnt;
  wire [NUM_M-1:0] onehot;
  wire owner_req;
  wire slot_hit;
  wire slot_brk;
  wire hold;
  wire [NUM_M-1:0] cand;
  wire [2:0] win;

  ////////////////////////////////////////////////////////////////////////
  // hold or break decision
  assign onehot = own_v ? ({{(NUM_M-1){1'b0}}, 1'b1} << owner) : {NUM_M{1'b0}};
  assign owner_req = own_v & req_i[owner];
  assign slot_hit = (slot_limit_i != {SLOT_W{1'b0}}) &&
                    ({1'b0, slot_cnt} + 1'b1 >= {1'b0, slot_limit_i}) && (|(req_i & ~onehot));
  assign slot_brk = owner_req & done_i & slot_hit & ~last_i[owner];
  assign hold = owner_req & ~(done_i & (last_i[owner] | slot_hit));
  assign cand = slot_brk ? (req_i & ~onehot) : req_i;
  assign win = pick(cand, rr_mode_i, last_win);
  assign grant_o = onehot;
  assign owner_o = owner;

  // grant register, slot counter and default master parking
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      owner <= 3'h0;
      own_v <= 1'b0;
      last_win <= LAST_M[2:0];
      slot_cnt <= {SLOT_W{1'b0}};
    end
    else if (hold)
    begin
      if (done_i)
        slot_cnt <= slot_cnt + 1'b1; // undefined length bursts just keep counting
    end
    else if (|cand)
    begin
      owner <= win;
      own_v <= 1'b1;
      last_win <= win;
      slot_cnt <= {SLOT_W{1'b0}};
    end
    else
    begin
      slot_cnt <= {SLOT_W{1'b0}};
      case (dm_type_i)
        `DM_LAST: own_v <= own_v;
        `DM_FIXED:
        begin
          owner <= dm_fixed_i;
          own_v <= 1'b1;
        end
        default: own_v <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verification/six_layer_bus_matrix_properties.sv ====
// checker: assertions on the bus matrix ports
`timescale 1ns/1ps
`default_nettype none
module bus_matrix_checker (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // boot and remap
  input wire logic [3:0] general_nonvolatile_bit_i,
  input wire logic remap_i,
  input wire logic boot_source_select_o,
  // masters
  input wire logic [5:0] m_req_i,
  input wire logic [5:0] m_write_i,
  input wire logic [5:0] m_ready_o,
  input wire logic [5:0] m_rvalid_o,
  input wire logic [5:0] m_err_o,
  // slaves
  input wire logic [5:0] s_sel_o,
  input wire logic [5:0] s_ready_i,
  input wire logic [191:0] s_addr_o,
  input wire logic [17:0] s_master_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////
  // boot bit is trusted a fixed time after reset
  sequence boot_ready;
    $fell(rst_i) ##5 1'h1;
  endsequence
  // a beat that the sram slave completes
  sequence sram_beat;
    s_sel_o[1] && s_ready_i[1];
  endsequence
  ////////////////////////
  boot_take_a:
  assert property (boot_ready |-> boot_source_select_o == general_nonvolatile_bit_i[3]) else $error("boot select");
  resv_idle_a:
  assert property (!s_sel_o[4]) else $error("reserved slave selected");
  eth_periph_a:
  assert property (s_sel_o[5] |-> s_master_o[17:15] != 3'h5) else $error("ethernet on peripherals");
  xfer_flash_a:
  assert property (s_sel_o[0] |-> s_master_o[2:0] != 3'h2) else $error("transfer engine on flash");
  remap_rom_a:
  assert property (s_sel_o[2] && remap_i |-> s_addr_o[95:84] != 12'h000) else $error("boot area to rom");
  beat_ready_a:
  assert property (sram_beat |-> m_ready_o[s_master_o[5:3]]) else $error("beat not acknowledged");
  sel_owner_a:
  assert property (s_sel_o[1] |-> m_req_i[s_master_o[5:3]]) else $error("select without request");
  err_cause_a:
  assert property (m_err_o[3] |-> $past(m_req_i[3] && m_ready_o[3])) else $error("abort without beat");
  rd_valid_a:
  assert property (m_rvalid_o[0] |-> $past(m_ready_o[0] && !m_write_i[0])) else $error("stray read data");
endmodule
bind six_layer_bus_matrix bus_matrix_checker chk_u (.sys_clk_i, .rst_i, .general_nonvolatile_bit_i, .remap_i,
  .boot_source_select_o, .m_req_i, .m_write_i, .m_ready_o, .m_rvalid_o, .m_err_o, .s_sel_o, .s_ready_i, .s_addr_o,
  .s_master_o);
`default_nettype wire

// ==== verification/slave_farm.sv ====
// partner: six behavioural slaves, prompt or stalling
`timescale 1ns/1ps
`default_nettype none
module slave_farm (
  // clock and mode
  input wire logic sys_clk_i,
  input wire logic slow_i,
  // slave ports
  input wire logic [5:0] sel_i,
  input wire logic [191:0] addr_i,
  output logic [5:0] ready_o,
  output logic [191:0] rdata_o
);
  logic [31:0] cnt = 32'h1;
  // pattern source for stalls and idle data
  always @(posedge sys_clk_i)
    cnt <= {cnt[30:0], cnt[31] ^ cnt[21] ^ cnt[1] ^ cnt[0]};
  // data marks the slave; unselected lines keep changing
  always @*
    for (int s = 0; s < 6; s++)
    begin
      ready_o[s] = !slow_i || cnt[s];
      rdata_o[s*32+:32] = sel_i[s] ? addr_i[s*32+:32] ^ {s[2:0], 29'h0} : ~cnt;
    end
endmodule
`default_nettype wire

// ==== verification/test_six_layer_bus_matrix.sv ====
// testbench: routing, boot, remap and arbitration checks
`timescale 1ns/1ps
`default_nettype none
module test_six_layer_bus_matrix;
  logic sys_clk_i = 0, rst_i = 1, remap_i = 0, slow = 0, boot_source_select_o;
  logic [3:0] general_nonvolatile_bit_i = 0;
  logic [5:0] rr_mode_i = 0, m_req_i = 0, m_last_i = 0, m_write_i = 0, s_ready_i, pe = 0, pr = 0;
  logic [5:0] m_ready_o, m_rvalid_o, m_err_o, s_sel_o, s_write_o, s_last_o;
  logic [11:0] dm_type_i = 0;
  logic [17:0] dm_fixed_i = 18'h2C688, s_master_o;
  logic [47:0] slot_limit_i = 0;
  logic [191:0] m_addr_i = 0, m_wdata_i = 0, m_rdata_o, s_addr_o, s_wdata_o, s_rdata_i;
  logic [31:0] seed = 32'hD7BD;
  logic [31:0] pd [6];
  int ordq [$];
  int num_errors = 0, cmp_count = 0, s;
  six_layer_bus_matrix dut_u (.sys_clk_i, .rst_i, .general_nonvolatile_bit_i, .remap_i, .boot_source_select_o,
    .rr_mode_i, .dm_type_i, .dm_fixed_i, .slot_limit_i, .m_req_i, .m_last_i, .m_write_i, .m_addr_i, .m_wdata_i,
    .m_ready_o, .m_rvalid_o, .m_err_o, .m_rdata_o, .s_sel_o, .s_write_o, .s_last_o, .s_addr_o, .s_wdata_o,
    .s_master_o, .s_ready_i, .s_rdata_i);
  slave_farm part_u (.sys_clk_i, .slow_i(slow), .sel_i(s_sel_o), .addr_i(s_addr_o), .ready_o(s_ready_i),
    .rdata_o(s_rdata_i));
  // clock
  always #2 sys_clk_i = ~sys_clk_i;
  ////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // slave for a master and address, 7 for abort; low bits allow masters
  function int route(int m, logic [31:0] a);
    logic [8:0] v;
    v = 9'h1C0;
    if (a[31:28] == 4'h0)
      case (a[27:20])
        8'h00: v = remap_i ? 9'h07F : general_nonvolatile_bit_i[3] ? 9'h023 : 9'h087;
        8'h01: v = 9'h087;
        8'h02: v = 9'h023;
        8'h03: v = 9'h07F;
        8'h05: v = 9'h083;
        default: v = 9'h1C0;
      endcase
    else if (a[31:28] <= 4'h7)
      v = 9'h0FF;
    else if (a[31:28] == 4'hF)
      v = 9'h147;
    return v[m] ? int'(v[8:6]) : 7;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////
  // response monitor: every answer against the routing model
  always @(negedge sys_clk_i)
    if (rst_i)
      {pe, pr} = 12'h000;
    else
      for (int m = 0; m < 6; m++)
      begin
        chk("err", pe[m], m_err_o[m]);
        chk("rvalid", pr[m], m_rvalid_o[m]);
        if (pr[m])
          chk("rdata", pd[m], m_rdata_o[m*32+:32]);
        s = route(m, m_addr_i[m*32+:32]);
        pe[m] = m_req_i[m] && m_ready_o[m] && s == 7;
        pr[m] = m_req_i[m] && m_ready_o[m] && s != 7 && !m_write_i[m];
        pd[m] = m_addr_i[m*32+:32] ^ {s[2:0], 29'h0};
        if (m_req_i[m] && m_ready_o[m])
          ordq.push_back(m);
        // a taken beat must stand on its slave with this master's own fields
        if (m_req_i[m] && m_ready_o[m] && s != 7)
        begin
          chk("slave sel", 1, s_sel_o[s]);
          chk("slave owner", m, s_master_o[s*3+:3]);
          chk("slave addr", m_addr_i[m*32+:32], s_addr_o[s*32+:32]);
          chk("slave wdata", m_wdata_i[m*32+:32], s_wdata_o[s*32+:32]);
          chk("slave ctl", {m_write_i[m], m_last_i[m]}, {s_write_o[s], s_last_o[s]});
        end
      end
  ////////////////////////
  task automatic burst(int m, int n, logic [31:0] a);
    int t;
    for (int i = 0; i < n; i++)
    begin
      m_req_i[m] <= 1'h1;
      m_last_i[m] <= i == n - 1;
      m_write_i[m] <= rnd() % 4 == 0;
      m_addr_i[m*32+:32] <= a + 4 * i;
      m_wdata_i[m*32+:32] <= rnd();
      t = 0;
      do
        @(negedge sys_clk_i);
      while (m_ready_o[m] !== 1'h1 && ++t < 300);
      if (t == 300)
        chk("ready", 1, 0);
      @(posedge sys_clk_i);
    end
  endtask
  // k bursts of n beats (0: random) at b (0: random address)
  task automatic run(int m, int k, int n, logic [31:0] b);
    logic [31:0] a;
    repeat (k)
    begin
      a = rnd() & 32'hFFFFFFF0;
      if (a[4])
        a[31:20] = {9'h000, a[7:5]};
      if (b != 0)
        a = b;
      burst(m, n ? n : 1 + a[9:8] % 3, a);
    end
    m_req_i[m] <= 1'h0;
    @(posedge sys_clk_i); // request stays low for one edge before the next run
  endtask
  task automatic reset(logic b);
    rst_i <= 1'h1;
    remap_i <= 1'h0;
    rr_mode_i <= 6'h00;
    dm_type_i <= 12'h000;
    slot_limit_i <= 48'h0;
    general_nonvolatile_bit_i <= {b, 3'h5};
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    repeat (6) @(posedge sys_clk_i);
    chk("boot", b, boot_source_select_o);
    ordq.delete();
  endtask
  // all six masters at once under random round-robin and slot setup, each default master kind on two slaves
  task automatic run_all();
    logic [31:0] r;
    r = rnd();
    rr_mode_i <= r[5:0];
    dm_type_i <= 12'h186;
    slot_limit_i <= {r, r[15:0]} & 48'h030303030303;
    fork
      run(0, 30, 0, 0);
      run(1, 30, 0, 0);
      run(2, 30, 0, 0);
      run(3, 30, 0, 0);
      run(4, 30, 0, 0);
      run(5, 30, 0, 0);
    join
    ordq.delete();
  endtask
  task automatic expect_order(int e[$]);
    chk("count", e.size(), ordq.size());
    foreach (e[i])
      chk("winner", e[i], ordq[i]);
    ordq.delete();
  endtask
  task automatic pair();
    fork
      run(1, 2, 1, 32'h00300040);
      run(2, 2, 1, 32'h00300080);
    join
  endtask
  ////////////////////////
  // main sequence
  initial
  begin
    reset(1'h0);
    run_all();
    remap_i <= 1'h1;
    slow <= 1'h1;
    run_all();
    reset(1'h1);
    run_all();
    reset(1'h0);
    pair();
    expect_order({1, 1, 2, 2});
    rr_mode_i <= 6'h3F;
    pair();
    expect_order({1, 2, 1, 2});
    rr_mode_i <= 6'h00;
    slot_limit_i <= 48'h000000000200;
    fork
      run(1, 1, 4, 32'h00300100);
      run(2, 1, 1, 32'h00300200);
    join
    expect_order({1, 1, 2, 1, 1});
    wrap_up();
  end
  // watchdog: far beyond the few thousand cycles the tests need
  initial
  begin
    #200000;
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
